// ### core/pdbo_consts.vh
// register offsets, field positions and reset values for the port block
`ifndef PDBO_CONSTS_VH
`define PDBO_CONSTS_VH
`define PDBO_OFF_PORT2_DATA 8'hA0
`define PDBO_OFF_PORT0_DIR_LOW 8'hAC
`define PDBO_OFF_PORT0_DIR_HIGH 8'hAD
`define PDBO_OFF_PORT1_DIR_LOW 8'hAE
`define PDBO_OFF_PORT1_DIR_HIGH 8'hAF
`define PDBO_OFF_PORT3_DATA 8'hB0
`define PDBO_OFF_PORT2_DIR_LOW 8'hB1
`define PDBO_OFF_PORT2_DIR_HIGH 8'hB2
`define PDBO_OFF_PORT3_DIR_LOW 8'hB3
`define PDBO_OFF_PORT3_DIR_HIGH 8'hB4
`define PDBO_OFF_PORT0_DATA 8'hB8
`define PDBO_OFF_PORT1_DATA 8'hB9
`define PDBO_OFF_STATUS 8'hBA
`define PDBO_BIT_P23_SEL 0
`define PDBO_BIT_P0_SEL 1
`define PDBO_MODE_BIDIR 2'h0
`define PDBO_MODE_CMOS 2'h1
`define PDBO_MODE_ODRAIN 2'h2
`define PDBO_MODE_INPUT 2'h3
`define PDBO_RST_DATA 8'hFF
`define PDBO_RST_DIR 8'h00
`endif

// ### core/pdbo_port_block.v
// four bit-programmable ports with direction fields and bus takeover
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`include "pdbo_consts.vh"

// Notes on behaviour
// - two-bit field picks driver: 00 weak pull-up, 01 CMOS, 10 drain, 11 in
// - low direction register holds pins 3..0, high holds 7..4, two bits each
// - port 0 selector clear or access pin low at reset: CMOS bus port
// - port 2 selector clear or access pin low at reset: CMOS bus port
// - either condition makes port 3 pins 6/7 CMOS write/read strobes
// - port 2 takeover drives high address on port 2; software leaves its data alone
// - every data register bit maps to one pin of its port
module pdbo_port_block
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  // configuration straps and access pin
  input wire hardware_config_one_i,
  input wire port0_gpio_select_i,
  input wire port23_gpio_select_i,
  input wire external_access_pin_i,
  // external memory engine side
  input wire [7:0] bus_low_addr_data_i,
  input wire bus_low_oe_i,
  input wire [7:0] bus_high_addr_i,
  input wire bus_write_strobe_n_i,
  input wire bus_read_strobe_n_i,
  output wire [7:0] bus_low_data_o,
  output wire bus_mode_o,
  // pins: ports 0..3 packed as 32 bits, port n at [8n+7:8n]
  input wire [31:0] pin_i,
  output wire [31:0] pin_o,
  output wire [31:0] pin_oe_o,
  output wire [31:0] pin_pullup_o
);

  reg [7:0] data_reg [0:3];
  reg [7:0] dir_low [0:3];
  reg [7:0] dir_high [0:3];
  reg [31:0] pin_meta;
  reg [31:0] pin_sync;
  reg ea_meta;
  reg ea_sync;
  reg rst_d;
  reg p0_bus;
  reg p2_bus;
  // register bus answer
  reg [31:0] rd_data;
  reg ack;
  // packed pin drive, three flops per pin inside the generate loop
  wire [31:0] pin_out_w;
  wire [31:0] pin_oe_w;
  wire [31:0] pin_pull_w;
  // combinational helpers
  reg [31:0] next_rd;
  reg [7:0] next_low_data;
  integer k;

  // a request is taken once; the pending ack blocks a second take
  wire req;
  wire wr;
  wire strobe_mode;
  assign req = cyc_i & stb_i & ~ack;
  assign wr = req & we_i & sel_i[0];
  // strobes go over whenever either port is handed to the bus
  assign strobe_mode = p0_bus | p2_bus;

  // two-stage synchronisers for pins and the access pin
  // only the second stage is read, so no logic sees a metastable level
  always @(posedge clk_i)
  begin
    pin_meta <= pin_i;
    pin_sync <= pin_meta;
    ea_meta <= external_access_pin_i;
    ea_sync <= ea_meta;
  end

  // capture bus mode on the first edge after reset release
  // the mode then holds until the next reset, whatever the straps do
  always @(posedge clk_i)
  begin
    rst_d <= rst_i;
    if (rst_i)
    begin
      p0_bus <= 1'b0;
      p2_bus <= 1'b0;
    end
    else if (rst_d)
    begin
      p0_bus <= ~(hardware_config_one_i & port0_gpio_select_i) | ~ea_sync;
      p2_bus <= ~(hardware_config_one_i & port23_gpio_select_i) | ~ea_sync;
    end
  end

  // register writes and single-cycle acknowledge
  // a write lands at the taking edge; unmapped offsets are acked and dropped
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
      for (k = 0; k < 4; k = k + 1)
      begin
        data_reg[k] <= `PDBO_RST_DATA;
        dir_low[k] <= `PDBO_RST_DIR;
        dir_high[k] <= `PDBO_RST_DIR;
      end
    end
    else
    begin
      ack <= req;
      if (wr)
      begin
        case (adr_i)
          `PDBO_OFF_PORT0_DATA: data_reg[0] <= dat_i[7:0];
          `PDBO_OFF_PORT1_DATA: data_reg[1] <= dat_i[7:0];
          `PDBO_OFF_PORT2_DATA: data_reg[2] <= dat_i[7:0];
          `PDBO_OFF_PORT3_DATA: data_reg[3] <= dat_i[7:0];
          `PDBO_OFF_PORT0_DIR_LOW: dir_low[0] <= dat_i[7:0];
          `PDBO_OFF_PORT0_DIR_HIGH: dir_high[0] <= dat_i[7:0];
          `PDBO_OFF_PORT1_DIR_LOW: dir_low[1] <= dat_i[7:0];
          `PDBO_OFF_PORT1_DIR_HIGH: dir_high[1] <= dat_i[7:0];
          `PDBO_OFF_PORT2_DIR_LOW: dir_low[2] <= dat_i[7:0];
          `PDBO_OFF_PORT2_DIR_HIGH: dir_high[2] <= dat_i[7:0];
          `PDBO_OFF_PORT3_DIR_LOW: dir_low[3] <= dat_i[7:0];
          `PDBO_OFF_PORT3_DIR_HIGH: dir_high[3] <= dat_i[7:0];
          default: ;
        endcase
      end
    end
  end

  // read mux: data offsets return synchronised pin levels
  always @*
  begin
    next_rd = 32'h00000000;
    case (adr_i)
      `PDBO_OFF_PORT0_DATA: next_rd[7:0] = pin_sync[7:0];
      `PDBO_OFF_PORT1_DATA: next_rd[7:0] = pin_sync[15:8];
      `PDBO_OFF_PORT2_DATA: next_rd[7:0] = pin_sync[23:16];
      `PDBO_OFF_PORT3_DATA: next_rd[7:0] = pin_sync[31:24];
      `PDBO_OFF_PORT0_DIR_LOW: next_rd[7:0] = dir_low[0];
      `PDBO_OFF_PORT0_DIR_HIGH: next_rd[7:0] = dir_high[0];
      `PDBO_OFF_PORT1_DIR_LOW: next_rd[7:0] = dir_low[1];
      `PDBO_OFF_PORT1_DIR_HIGH: next_rd[7:0] = dir_high[1];
      `PDBO_OFF_PORT2_DIR_LOW: next_rd[7:0] = dir_low[2];
      `PDBO_OFF_PORT2_DIR_HIGH: next_rd[7:0] = dir_high[2];
      `PDBO_OFF_PORT3_DIR_LOW: next_rd[7:0] = dir_low[3];
      `PDBO_OFF_PORT3_DIR_HIGH: next_rd[7:0] = dir_high[3];
      `PDBO_OFF_STATUS: next_rd[2:0] = {ea_sync, p2_bus, p0_bus};
      default: next_rd = 32'h00000000;
    endcase
  end

  // registered read data, held until the next read is taken
  always @(posedge clk_i)
  begin
    if (rst_i)
      rd_data <= 32'h00000000;
    else if (req & ~we_i)
      rd_data <= next_rd;
  end

  // per-pin driver selection; port n owns pins [8n+7:8n]
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : pin_gen
      // port index and bit index within the port
      localparam P = g / 8;
      localparam B = g % 8;
      // pins 3..0 read the low register, pins 7..4 the high one
      wire [7:0] dsel;
      wire [1:0] mode;
      wire dbit;
      // takeover conditions for this particular pin
      wire take_p0;
      wire take_p2;
      wire take_strobe;
      reg o;
      reg oe;
      reg pu;
      reg o_q;
      reg oe_q;
      reg pu_q;
      assign dsel = (B < 4) ? dir_low[P] : dir_high[P];
      assign mode = dsel[2*(B%4)+1 -: 2];
      assign dbit = data_reg[P][B];
      assign take_p0 = (P == 0) && p0_bus;
      assign take_p2 = (P == 2) && p2_bus;
      assign take_strobe = (P == 3) && (B >= 6) && strobe_mode;
      // direction field first, then the bus takeover overrides it
      always @*
      begin
        o = dbit;
        oe = 1'b0;
        pu = 1'b0;
        case (mode)
          `PDBO_MODE_BIDIR:
          begin
            oe = ~dbit;
            o = 1'b0;
            pu = 1'b1;
          end
          `PDBO_MODE_CMOS: oe = 1'b1;
          `PDBO_MODE_ODRAIN:
          begin
            oe = ~dbit;
            o = 1'b0;
          end
          `PDBO_MODE_INPUT: oe = 1'b0;
          default: oe = 1'b0;
        endcase
        // bus ports ignore their direction fields entirely
        if (take_p0)
        begin
          o = bus_low_addr_data_i[B];
          oe = bus_low_oe_i;
          pu = 1'b0;
        end
        if (take_p2)
        begin
          o = bus_high_addr_i[B];
          oe = 1'b1;
          pu = 1'b0;
        end
        if (take_strobe)
        begin
          o = (B == 6) ? bus_write_strobe_n_i : bus_read_strobe_n_i;
          oe = 1'b1;
          pu = 1'b0;
        end
      end
      // registered pin drive; driver off and pull-up on during reset
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          o_q <= 1'b0;
          oe_q <= 1'b0;
          pu_q <= 1'b1;
        end
        else
        begin
          o_q <= o;
          oe_q <= oe;
          pu_q <= pu;
        end
      end
      // gather the per-pin flops into the packed pin vectors
      assign pin_out_w[g] = o_q;
      assign pin_oe_w[g] = oe_q;
      assign pin_pull_w[g] = pu_q;
    end
  endgenerate

  // low bus byte back to the memory engine
  // taken from the synchronised pins, so it lags the pads by two edges
  always @*
  begin
    next_low_data = pin_sync[7:0];
  end

  assign dat_o = rd_data;
  assign ack_o = ack;
  assign pin_o = pin_out_w;
  assign pin_oe_o = pin_oe_w;
  assign pin_pullup_o = pin_pull_w;
  assign bus_low_data_o = next_low_data;
  assign bus_mode_o = strobe_mode;

endmodule

// ### dv/pdbo_pad_model.sv
// pads: device drive wins, then outside drive, then pull-up
`timescale 1ns/1ps
module pdbo_pad_model
(
  // device and outside drive
  input wire [31:0] o_i,
  input wire [31:0] oe_i,
  input wire [31:0] pu_i,
  input wire [31:0] xe_i,
  input wire [31:0] xv_i,
  // resolved level
  output wire [31:0] pad_o
);
  // unpulled floating pads read the inverse of the device data
  assign pad_o = oe_i & o_i | ~oe_i & (xe_i & xv_i | ~xe_i & (pu_i | ~o_i));
endmodule

// ### dv/pdbo_port_block_chk.sv
// handshake and pin takeover assertions for the port block
`timescale 1ns/1ps
module pdbo_port_block_chk
(
  // clock, reset, bus
  input wire clk_i,
  input wire rst_i,
  input wire stb_i,
  input wire ack_o,
  // straps and bus engine
  input wire hardware_config_one_i,
  input wire external_access_pin_i,
  input wire port0_gpio_select_i,
  input wire port23_gpio_select_i,
  input wire bus_low_oe_i,
  input wire [7:0] bus_high_addr_i,
  input wire bus_write_strobe_n_i,
  input wire bus_read_strobe_n_i,
  // outputs
  input wire bus_mode_o,
  input wire [31:0] pin_o,
  input wire [31:0] pin_oe_o,
  input wire [31:0] pin_pullup_o
);
  logic [1:0] live;
  wire bm = live[1] && bus_mode_o;
  wire ea_low = !external_access_pin_i || !hardware_config_one_i;
  wire p0_take = live[1] && (ea_low || !port0_gpio_select_i);
  wire p2_take = live[1] && (ea_low || !port23_gpio_select_i);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // marks edges well clear of reset release
  always @(posedge clk_i)
    live <= rst_i ? 2'h0 : {live[0], 1'h1};
  // one-cycle answer
  a_ack_next: assert property (stb_i && !ack_o |=> ack_o) else $error("ack");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack long");
  a_ack_cause: assert property ($rose(ack_o) |-> $past(stb_i))
    else $error("ack cause");
  // takeover outputs in bus mode, and no pulled-up pin driven high
  a_wr_strobe: assert property (bm |-> pin_oe_o[30] &&
    pin_o[30] == $past(bus_write_strobe_n_i)) else $error("wr strobe");
  a_rd_strobe: assert property (bm |-> pin_oe_o[31] &&
    pin_o[31] == $past(bus_read_strobe_n_i)) else $error("rd strobe");
  a_high_addr: assert property (p2_take |-> pin_oe_o[23:16] == 8'hFF &&
    pin_o[23:16] == $past(bus_high_addr_i)) else $error("high addr");
  a_low_drive: assert property (p0_take |->
    pin_oe_o[7:0] == {8{$past(bus_low_oe_i)}}) else $error("low bus");
  a_pull_low: assert property ((pin_oe_o & pin_pullup_o & pin_o) == 0)
    else $error("pulled high drive");
endmodule
bind pdbo_port_block pdbo_port_block_chk pdbo_port_block_chk_i (.*);

// ### dv/test_pdbo_port_block.sv
// self-checking bench: pin drive, read-back and bus takeover
`timescale 1ns/1ps
module test_pdbo_port_block;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic hardware_config_one_i = 1'h1, port0_gpio_select_i = 1'h1;
  logic port23_gpio_select_i = 1'h1, external_access_pin_i = 1'h1;
  logic bus_low_oe_i = 1'h1, bus_write_strobe_n_i = 1'h0;
  logic bus_read_strobe_n_i = 1'h1, ack_o, bus_mode_o;
  logic [7:0] adr_i = 8'h0, bus_low_addr_data_i = 8'h3C, bus_low_data_o, q;
  logic [7:0] bus_high_addr_i = 8'hC3;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o, pin_i, pin_o, pin_oe_o, pin_pullup_o;
  logic [31:0] xe = 32'h0, xv = 32'h0;
  integer error_cnt = 0, compares = 0;
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  // block and pads
  pdbo_port_block pdbo_port_block_i (.*);
  pdbo_pad_model pdbo_pad_model_i
  (
    .o_i(pin_o), .oe_i(pin_oe_o), .pu_i(pin_pullup_o), .xe_i(xe), .xv_i(xv),
    .pad_o(pin_i)
  );
  // compare and count
  task cmp(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    error_cnt += (seen !== exp);
    if (seen !== exp)
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
  endtask
  // wishbone single cycle held until ack
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, 24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'h1)
      @(posedge clk_i);
    q = dat_o[7:0];
    {cyc_i, stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  // reset with straps held across release
  task boot(input logic [2:0] s);
    @(posedge clk_i);
    rst_i <= 1'h1;
    {external_access_pin_i, port0_gpio_select_i, port23_gpio_select_i} <= s;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
  endtask
  // driver type per pin, read-back and pin inputs on ports 1 and 3
  task t_modes;
    boot(3'h7);
    wb(1'h1, 8'hAE, 8'hE4);
    wb(1'h1, 8'hAF, 8'h40);
    wb(1'h1, 8'hB9, 8'hFA);
    cmp(pin_oe_o[15:8], 8'h87);
    cmp({4'h0, pin_o[15], pin_o[10:8]}, 8'h0A);
    wb(1'h1, 8'hB9, 8'h05);
    cmp(pin_oe_o[15:8], 8'hF2);
    wb(1'h0, 8'hAE, 8'h00);
    cmp(q, 8'hE4);
    wb(1'h0, 8'h10, 8'h00);
    cmp(q, 8'h00);
    xe <= 32'h0100FF00;
    xv <= 32'h00005A00;
    wb(1'h1, 8'hAF, 8'hFF);
    wb(1'h1, 8'hAE, 8'hFF);
    wb(1'h1, 8'hB3, 8'h03);
    wb(1'h0, 8'hB9, 8'h00);
    cmp(q, 8'h5A);
    wb(1'h0, 8'hB0, 8'h00);
    cmp(q, 8'hFE);
    $display("modes end");
  endtask
  // access pin low takes all, then port 0 select alone
  task t_bus;
    boot(3'h3);
    wb(1'h1, 8'hB1, 8'hAA);
    wb(1'h1, 8'hB4, 8'hFF);
    cmp(pin_oe_o[23:16], 8'hFF);
    cmp(pin_o[23:16], 8'hC3);
    cmp({4'h0, pin_oe_o[31:30], pin_o[31:30]}, 8'h0E);
    cmp(pin_o[7:0], 8'h3C);
    {bus_write_strobe_n_i, bus_read_strobe_n_i} <= 2'h2;
    bus_low_addr_data_i <= 8'h5A;
    boot(3'h5);
    wb(1'h1, 8'hB1, 8'h55);
    wb(1'h1, 8'hA0, 8'hF9);
    cmp(pin_oe_o[23:16], 8'h0F);
    cmp({4'h0, pin_oe_o[31:30], pin_o[31:30]}, 8'h0D);
    cmp(pin_o[7:0], 8'h5A);
    $display("bus end");
  endtask
  // verdict
  task results;
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial
  begin
    t_modes;
    t_bus;
    results;
  end
  // watchdog far beyond the fewer than a hundred cycles needed
  initial
  begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    results;
  end
endmodule
